// ==== regview_pkg.sv ====
// Package: register indices, reset values and field positions for the general register block
package regview_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;  // Register index width
  localparam int unsigned DATA_W = 16; // Data path width
  localparam int unsigned BYTE_W = 8;  // Byte width

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_POINTER_CONTROL = 5'h04; // Index chosen locally
  localparam logic [ADDR_W-1:0] IDX_GENERAL = 5'h05;         // Full 16-bit register
  localparam logic [ADDR_W-1:0] IDX_LOW_BYTE = 5'h06;        // Low byte location
  localparam logic [ADDR_W-1:0] IDX_SWAPPED = 5'h08;         // Byte-swapped view
  localparam logic [ADDR_W-1:0] IDX_HIGH_BYTE = 5'h09;       // High byte location
  localparam logic [ADDR_W-1:0] IDX_SIGN_EXT = 5'h0a;        // Sign-extended low byte

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] GENERAL_RESET = 16'h0000;   // General register reset
  localparam logic [DATA_W-1:0] CONTROL_RESET = 16'h0004;   // Pointer control reset
  localparam int unsigned WIDTH_SELECT_BIT = 2;             // Word/byte select position
  localparam logic [DATA_W-1:0] CONTROL_MASK = 16'h0004;    // Implemented control bits
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;       // Unmapped read value

endpackage : regview_pkg

// ==== regview_if.sv ====
// Interface: general register value and its write port between modules
`timescale 1ns/1ns
`default_nettype none
interface regview_if;
  import regview_pkg::*;
  logic [DATA_W-1:0] value;   // Stored general register
  logic wr_low;               // Low byte write strobe
  logic wr_high;              // High byte write strobe
  logic [DATA_W-1:0] wr_data; // Write data, low byte in [7:0] for byte writes

  // Storage side drives value
  modport store (
    output value,
    input wr_low,
    input wr_high,
    input wr_data
  );

  // Decoder side drives strobes
  modport access (
    input value,
    output wr_low,
    output wr_high,
    output wr_data
  );
endinterface : regview_if
`default_nettype wire

// ==== general_store.sv ====
// Storage for the 16-bit general register with per-byte writes
`timescale 1ns/1ns
`default_nettype none
module general_store (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic byte_mode_i,
  regview_if.store bus
);
  import regview_pkg::*;

  logic [DATA_W-1:0] word;      // Held value
  logic [DATA_W-1:0] next_word; // Next held value

  // Byte steering; byte_mode_i places a byte write from the low data lane
  always_comb
  begin
    next_word = word;
    if (bus.wr_low)
    begin
      next_word[BYTE_W-1:0] = bus.wr_data[BYTE_W-1:0];
    end
    if (bus.wr_high)
    begin
      // Upper lane when both strobes, low lane for a lone high-byte write
      next_word[DATA_W-1:BYTE_W] = byte_mode_i ?
        bus.wr_data[BYTE_W-1:0] : bus.wr_data[DATA_W-1:BYTE_W];
    end
  end

  // Register stage
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      word <= GENERAL_RESET;
    end
    else
    begin
      word <= next_word;
    end
  end

  assign bus.value = word;

endmodule : general_store
`default_nettype wire

// ==== view_mux.sv ====
// Read multiplexer for the general register views
`timescale 1ns/1ns
`default_nettype none
module view_mux (
  input wire logic [regview_pkg::ADDR_W-1:0] addr_i,
  input wire logic [regview_pkg::DATA_W-1:0] general_i,
  input wire logic [regview_pkg::DATA_W-1:0] control_i,
  output logic [regview_pkg::DATA_W-1:0] data_o
);
  import regview_pkg::*;

  // Views derived combinationally, so they follow reset of the store
  always_comb
  begin
    case (addr_i)
      IDX_GENERAL: data_o = general_i;
      IDX_LOW_BYTE: data_o = {{BYTE_W{1'b0}}, general_i[BYTE_W-1:0]};
      IDX_HIGH_BYTE: data_o = {{BYTE_W{1'b0}}, general_i[DATA_W-1:BYTE_W]};
      IDX_SWAPPED: data_o = {general_i[BYTE_W-1:0], general_i[DATA_W-1:BYTE_W]};
      IDX_SIGN_EXT: data_o = {{BYTE_W{general_i[BYTE_W-1]}},
                              general_i[BYTE_W-1:0]};
      IDX_POINTER_CONTROL: data_o = control_i & CONTROL_MASK;
      default: data_o = ZERO_WORD;
    endcase
  end

endmodule : view_mux
`default_nettype wire

// ==== general_register_byte_views.sv ====
// Top: general register byte views and pointer control register
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// Function
// ------------------------------------------------------------------
//
// Function
// - Pointer control resets to 0004h
// - Bit 2 selects word or byte pointer access
// - Control bits 15 to 3 read zero
// - General register 16 bits, resets zero
// - Low and high bytes reset zero
// - Low byte write changes bits 7-0 only
// - Low byte read returns bits 7-0
// - High byte write changes bits 15-8 only
// - High byte read returns bits 15-8
// - Swap view exchanges the two bytes
// - Sign view upper byte copies bit 7
// - Sign view lower byte is low byte
// - Swap and sign views read zero after reset
module general_register_byte_views (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [regview_pkg::ADDR_W-1:0] addr_i,
  input wire logic [regview_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [regview_pkg::DATA_W-1:0] rdata_o,
  output logic pointer_word_mode_o
);
  import regview_pkg::*;

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  regview_if gr ();                      // Store/decoder link
  logic [DATA_W-1:0] control;            // Pointer control register
  logic [DATA_W-1:0] next_control;       // Next control value
  logic [DATA_W-1:0] rdata;              // Read data register
  logic [DATA_W-1:0] next_rdata;         // Next read data
  logic word_mode;                       // Registered pointer width select
  logic next_word_mode;                  // Next width select
  logic [DATA_W-1:0] view_data;          // Mux output
  logic byte_mode;                       // Current access is the high byte location

  // Decode helper, used by strobes and steering
  function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
    hits = (a == idx);
  endfunction : hits

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Read-only view indices fall through: no strobe, no change
  always_comb
  begin
    gr.wr_low = wr_i && (hits(addr_i, IDX_GENERAL) || hits(addr_i, IDX_LOW_BYTE));
    gr.wr_high = wr_i && (hits(addr_i, IDX_GENERAL) || hits(addr_i, IDX_HIGH_BYTE));
    gr.wr_data = wdata_i;
    byte_mode = hits(addr_i, IDX_HIGH_BYTE);
  end

  general_store u_store (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .byte_mode_i(byte_mode),
    .bus(gr.store)
  );

  view_mux u_mux (
    .addr_i(addr_i),
    .general_i(gr.value),
    .control_i(control),
    .data_o(view_data)
  );

  // ----------------------------------------------------------------
  // Control register and read path
  // ----------------------------------------------------------------
  // Only the implemented bit is kept, so reserved bits cannot store
  always_comb
  begin
    next_control = control;
    if (wr_i && hits(addr_i, IDX_POINTER_CONTROL))
    begin
      next_control = wdata_i & CONTROL_MASK;
    end
    next_word_mode = next_control[WIDTH_SELECT_BIT];
    next_rdata = rd_i ? view_data : ZERO_WORD;
  end

  // Register stage; read data stand one cycle only
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      control <= CONTROL_RESET;
      word_mode <= CONTROL_RESET[WIDTH_SELECT_BIT];
      rdata <= ZERO_WORD;
    end
    else
    begin
      control <= next_control;
      word_mode <= next_word_mode;
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;
  assign pointer_word_mode_o = word_mode;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  control_reset_a: assert property (@(posedge clk_i) srst_i |=> control == 16'h0004 && pointer_word_mode_o)
    else $error("control not 0004h after reset");
  width_select_a: assert property (@(posedge clk_i) disable iff (srst_i) pointer_word_mode_o == control[2])
    else $error("width select mismatch");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
    rd_i && addr_i == IDX_POINTER_CONTROL |=> rdata_o[15:3] == 13'h0000)
    else $error("reserved control bits not zero");
  general_reset_a: assert property (@(posedge clk_i) srst_i |=> gr.value == 16'h0000)
    else $error("general register not cleared");
  low_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_i && addr_i == IDX_LOW_BYTE |=> gr.value == {$past(gr.value[15:8]), $past(wdata_i[7:0])})
    else $error("low byte write wrong");
  high_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_i && addr_i == IDX_HIGH_BYTE |=> gr.value == {$past(wdata_i[7:0]), $past(gr.value[7:0])})
    else $error("high byte write wrong");
  swap_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
    rd_i && !wr_i && addr_i == IDX_SWAPPED |=> rdata_o == {gr.value[7:0], gr.value[15:8]})
    else $error("swap view wrong");
  sign_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
    rd_i && !wr_i && addr_i == IDX_SIGN_EXT |=> rdata_o == {{8{gr.value[7]}}, gr.value[7:0]})
    else $error("sign view wrong");
  ro_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_i && (addr_i == IDX_SWAPPED || addr_i == IDX_SIGN_EXT) |=> $stable(gr.value))
    else $error("read-only write changed register");

endmodule : general_register_byte_views
`default_nettype wire

// ==== core_model.sv ====
// Partner model: instruction core issuing cycles on the register bus
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic clk_i,
  input wire logic [regview_pkg::DATA_W-1:0] rdata_i,
  output logic [regview_pkg::ADDR_W-1:0] addr_o,
  output logic [regview_pkg::DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  import regview_pkg::*;

  // Idle bus at time zero
  initial
  begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One-cycle write; lines scrambled afterwards so stale data cannot pass
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : bus_write

  // One-cycle read; data is taken in the cycle after the strobe only
  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask : bus_read
endmodule : core_model
`default_nettype wire

// ==== test_general_register_byte_views.sv ====
// Testbench: random and corner accesses to the general register views
`timescale 1ns/1ns
`default_nettype none
module test_general_register_byte_views;
  import regview_pkg::*;

  // ------------------------------------------------------------
  // Signals and reference state
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1; // Held for the first ten cycles
  wire logic [ADDR_W-1:0] addr;
  wire logic [DATA_W-1:0] wdata;
  wire logic wr;
  wire logic rd;
  logic [DATA_W-1:0] rdata;
  logic word_mode;
  logic [DATA_W-1:0] g = GENERAL_RESET; // Expected general register
  logic [DATA_W-1:0] c = CONTROL_RESET; // Expected pointer control
  int fail_count = 0;
  int n_tests = 0;
  // Every mapped index plus two unmapped ones
  localparam logic [ADDR_W-1:0] OPS [8] = '{IDX_POINTER_CONTROL, IDX_GENERAL,
    IDX_LOW_BYTE, IDX_SWAPPED, IDX_HIGH_BYTE, IDX_SIGN_EXT, 5'h07, 5'h1f};
  localparam logic [DATA_W-1:0] CORNERS [4] = '{16'h0080, 16'h007f, 16'hff80, 16'h0001};

  core_model u_core (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  general_register_byte_views u_dut (.clk_i(clk), .srst_i(srst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pointer_word_mode_o(word_mode));

  // 100 ns clock
  initial
  begin
    forever #50 clk = ~clk;
  end

  // Expected read data for one index
  function automatic logic [DATA_W-1:0] expect_read(input logic [ADDR_W-1:0] a);
    case (a)
      IDX_POINTER_CONTROL: return c;
      IDX_GENERAL: return g;
      IDX_LOW_BYTE: return {8'h00, g[7:0]};
      IDX_SWAPPED: return {g[7:0], g[15:8]};
      IDX_HIGH_BYTE: return {8'h00, g[15:8]};
      IDX_SIGN_EXT: return {{8{g[7]}}, g[7:0]};
      default: return ZERO_WORD;
    endcase
  endfunction : expect_read

  task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Read every location and the mode pin against the reference
  task automatic check_all(input string name);
    logic [DATA_W-1:0] d;
    foreach (OPS[i])
    begin
      u_core.bus_read(OPS[i], d);
      check($sformatf("index %h", OPS[i]), expect_read(OPS[i]), d);
    end
    check("word mode", {15'h0000, c[WIDTH_SELECT_BIT]}, {15'h0000, word_mode});
    $display("test %s done", name);
  endtask : check_all

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Cut a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    void'($urandom(32'h64d8));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    check_all("reset values");
    for (int n = 0; n < 40; n++)
    begin
      // Sign-bit corners first, then random traffic
      a = (n < 4) ? (n[0] ? IDX_HIGH_BYTE : IDX_LOW_BYTE) : OPS[$urandom_range(7)];
      d = (n < 4) ? CORNERS[n] : DATA_W'($urandom());
      u_core.bus_write(a, d);
      case (a)
        IDX_GENERAL: g = d;
        IDX_LOW_BYTE: g[7:0] = d[7:0];
        IDX_HIGH_BYTE: g[15:8] = d[7:0];
        IDX_POINTER_CONTROL: c = d & CONTROL_MASK;
        default: ; // Read-only and unmapped writes change nothing
      endcase
      check_all($sformatf("write %h data %h", a, d));
    end
    // Reset again after the write loop, before the final check
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    g = GENERAL_RESET;
    c = CONTROL_RESET;
    check_all("second reset");
    wrap_up();
  end
endmodule : test_general_register_byte_views
`default_nettype wire
